// File: rtl/tdc_readout_pkg.sv
package tdc_readout_pkg;

    // Serial opcodes
    localparam logic [3:0] OP_READ_HIGH   = 4'hB;
    localparam logic [7:0] OP_READ_ID     = 8'hB7;
    localparam logic [4:0] OP_WRITE_HIGH  = 5'h10;
    localparam logic [7:0] OP_NVM_STORE   = 8'hC0;
    localparam logic [7:0] OP_NVM_RECALL  = 8'hF0;
    localparam logic [7:0] OP_NVM_COMPARE = 8'hC5;

    // Read addresses and answer lengths in bytes
    localparam logic [2:0] ADDR_RESULT_LAST = 3'h3;
    localparam logic [2:0] ADDR_STATUS      = 3'h4;
    localparam logic [2:0] ADDR_TEST        = 3'h5;
    localparam logic [3:0] RESULT_BYTES     = 4'h4;
    localparam logic [3:0] STATUS_BYTES     = 4'h2;
    localparam logic [3:0] TEST_BYTES       = 4'h1;
    localparam logic [3:0] ID_BYTES         = 4'h7;

    // Configuration words, writes of 3 or 4 data bytes
    localparam int         CFG_WORDS     = 7;
    localparam logic [2:0] CFG_ADDR_LAST = 3'h6;
    localparam logic [3:0] WRITE_UPPER   = 4'h3;
    localparam logic [3:0] WRITE_LOWER   = 4'h4;
    localparam int         TEST_CFG_WORD = 1;

    // Result formats
    localparam logic [31:0] RESULT_RESET    = 32'h0000_0000;
    localparam logic [31:0] RESULT_OVERFLOW = 32'hFFFF_FFFF;
    localparam logic [15:0] RAW_LOW_WORD    = 16'h0000;
    localparam logic [15:0] STATUS_RESET    = 16'h0000;

    // Protected word: 32 data, 6 check, 1 overall parity
    localparam int ECC_WIDTH = 39;

    // Store, recall and compare duration
    localparam int NVM_ACTION_TIME_MS = 130;
    localparam int REF_CLK_HZ         = 10_000_000;
    localparam int NVM_ACTION_CYCLES  = NVM_ACTION_TIME_MS * (REF_CLK_HZ / 1000);

    typedef enum logic [1:0] {MODE1_CAL, MODE1_RAW, MODE2, TEMPERATURE} result_kind_type;
    typedef enum logic [1:0] {NVM_STORE, NVM_RECALL, NVM_COMPARE} nvm_op_type;

    typedef struct packed {
        logic            valid;
        logic [1:0]      index;
        result_kind_type kind;
        logic            alu_overflow;
        logic [31:0]     value;
    } result_write_type;

    typedef struct packed {
        logic       sensor_short;
        logic       sensor_open;
        logic       precount_timeout;
        logic       tdc_timeout;
        logic [2:0] hits_ch2;
        logic [2:0] hits_ch1;
        logic [2:0] next_pointer;
    } engine_status_type;

    typedef struct packed {
        logic single_fixed;
        logic nvm_uncorrectable_flag;
        logic nvm_matches_config;
    } nvm_flags_type;

endpackage

// File: rtl/nvm_config_store.sv
`timescale 1ns/1ps
module nvm_config_store #(
    parameter int ACTION_CYCLES = tdc_readout_pkg::NVM_ACTION_CYCLES
) (
    // Clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    // Action request
    input  wire logic                                 start,
    input  wire tdc_readout_pkg::nvm_op_type          op,
    input  wire logic [6:0][31:0]                     cfg_words,
    input  wire logic [38:0]                          fault_mask,
    // Results
    output logic                                      busy,
    output logic                                      done,
    output logic                                      recall_valid,
    output logic [6:0][31:0]                          recall_words,
    output tdc_readout_pkg::nvm_flags_type            flags
);
    import tdc_readout_pkg::*;

    logic [ECC_WIDTH-1:0] cells_q [CFG_WORDS];
    logic [31:0]          count_q;
    nvm_op_type           op_q;
    logic [6:0][31:0]     decoded;
    logic                 any_single;
    logic                 any_multi;
    logic                 all_equal;

    // Hamming positions 1..38, overall parity at bit 0
    function automatic logic [ECC_WIDTH-1:0] ecc_encode(input logic [31:0] d);
        logic [ECC_WIDTH-1:0] c;
        int                   k;
        c = '0;
        k = 0;
        for (int p = 1; p < ECC_WIDTH; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[k];
                k++;
            end
        end
        for (int i = 0; i < 6; i++) begin
            for (int p = 1; p < ECC_WIDTH; p++) begin
                if (((p >> i) & 1) == 1 && p != (1 << i)) begin
                    c[1 << i] = c[1 << i] ^ c[p];
                end
            end
        end
        c[0] = ^c[ECC_WIDTH-1:1];
        return c;
    endfunction

    // Returns {multi, single, data}
    function automatic logic [33:0] ecc_decode(input logic [ECC_WIDTH-1:0] cw);
        logic [ECC_WIDTH-1:0] c;
        logic [5:0]           s;
        logic [31:0]          d;
        logic                 single;
        logic                 multi;
        int                   k;
        c = cw;
        s = '0;
        d = '0;
        k = 0;
        for (int p = 1; p < ECC_WIDTH; p++) begin
            if (c[p]) begin
                s = s ^ 6'(p);
            end
        end
        single = (^c) && (int'(s) < ECC_WIDTH);
        multi  = (s != '0) && !single;
        if (single && s != '0) begin
            c[s] = ~c[s];
        end
        for (int p = 1; p < ECC_WIDTH; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[k] = c[p];
                k++;
            end
        end
        return {multi, single, d};
    endfunction

    // Decode and check every stored word
    always_comb begin
        logic [33:0] r;
        r          = '0;
        any_single = 1'b0;
        any_multi  = 1'b0;
        all_equal  = 1'b1;
        for (int w = 0; w < CFG_WORDS; w++) begin
            r          = ecc_decode(cells_q[w]);
            decoded[w] = r[31:0];
            any_single = any_single | r[32];
            any_multi  = any_multi | r[33];
            all_equal  = all_equal & (r[31:0] == cfg_words[w]);
        end
    end

    // Action timer
    always_ff @(posedge clk) begin
        if (rst) begin
            busy    <= 1'b0;
            done    <= 1'b0;
            count_q <= '0;
            op_q    <= NVM_STORE;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy    <= 1'b1;
                op_q    <= op;
                count_q <= 32'(ACTION_CYCLES - 1);
            end else if (busy) begin
                if (count_q == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_q <= count_q - 32'h0000_0001;
                end
            end
        end
    end

    // Cells, recall data and flags at the end of an action
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int w = 0; w < CFG_WORDS; w++) begin
                cells_q[w] <= '0;
            end
            recall_valid <= 1'b0;
            recall_words <= '0;
            flags        <= '0;
        end else begin
            recall_valid <= 1'b0;
            if (busy && count_q == '0) begin
                unique case (op_q)
                    NVM_STORE: begin
                        for (int w = 0; w < CFG_WORDS; w++) begin
                            cells_q[w] <= ecc_encode(cfg_words[w]) ^ (w == 0 ? fault_mask : '0);
                        end
                        flags <= '0;
                    end
                    NVM_RECALL: begin
                        recall_valid <= !any_multi;
                        recall_words <= decoded;
                        flags        <= '{any_single, any_multi, 1'b0};
                    end
                    NVM_COMPARE: begin
                        flags <= '{any_single, any_multi, all_equal};
                    end
                    default: flags <= '0;
                endcase
            end
        end
    end

endmodule // nvm_config_store

// File: rtl/tdc_result_status_readout.sv
// Function
// - Opcodes 0xB0-0xB4 read result or status bytes
// - ID opcode sends seven ID bytes, MSB first
// - Addresses 0-3 hold four 32-bit results
// - Status: pointer and two hit counters
// - Status flags converter and precounter overflow
// - Status flags open and shorted sensor
// - Status bit 13 shows compare match
// - Status bits for corrected and uncorrectable errors
// - Mode 2 results are unsigned
// - Uncalibrated output only in mode 1
// - Mode 1 calibrated overflow writes all ones
// - Calibrated results sent from weight 2^15 down
// - Raw result in high half, low zero
// - Temperature uses mode 2 format
// - Seven-word store with store, recall, compare
// - No serial read of stored configuration
// - Hamming code corrects single, detects double errors
// - Four-wire port with active-low select only
// - Clock idles low, sample on trailing edge
// - Bytewise MSB first; select high resets port
// - Store actions last up to 130 ms
`timescale 1ns/1ps
module tdc_result_status_readout #(
    parameter int NVM_CYCLES = tdc_readout_pkg::NVM_ACTION_CYCLES
) (
    // Clock and reset
    input  wire logic                                 REF_CLK,
    input  wire logic                                 RST,
    // Serial port
    input  wire logic                                 SERIAL_SELECT_LOW,
    input  wire logic                                 SERIAL_CLOCK,
    input  wire logic                                 SERIAL_DATA_IN,
    output logic                                      SERIAL_DATA_OUT,
    output logic                                      SERIAL_DATA_OUT_EN,
    // Measurement engine
    input  wire tdc_readout_pkg::result_write_type    RESULT_WRITE,
    input  wire tdc_readout_pkg::engine_status_type   ENGINE_STATUS,
    // Configuration and store
    input  wire logic [38:0]                          NVM_FAULT_MASK,
    output logic [6:0][31:0]                          CONFIG_WORDS,
    output logic                                      NVM_BUSY,
    output logic                                      NVM_DONE
);
    import tdc_readout_pkg::*;

    logic              sck_q;
    logic [2:0]        bit_cnt_q;
    logic [3:0]        byte_cnt_q;
    logic [7:0]        shift_in_q;
    logic [7:0]        opcode_q;
    logic [7:0]        shift_out_q;
    logic [15:0]       write_acc_q;
    logic [31:0]       results_q [4];
    logic [15:0]       status_q;
    logic              nvm_start_q;
    nvm_op_type        nvm_op_q;
    logic              nvm_done;
    logic              recall_valid;
    logic [6:0][31:0]  recall_words;
    nvm_flags_type     nvm_flags;
    logic              sck_rise;
    logic              sck_fall;
    logic              selected;
    logic              byte_done;
    logic [7:0]        byte_in;
    logic [7:0]        next_byte;
    logic [3:0]        data_index;
    logic              is_read;
    logic              is_id;
    logic              is_write;
    logic [2:0]        op_addr;

    // Result formatting per measure mode
    function automatic logic [31:0] format_result(input result_write_type w);
        logic [31:0] r;
        unique case (w.kind)
            MODE1_CAL:   r = w.alu_overflow ? RESULT_OVERFLOW : w.value;
            MODE1_RAW:   r = {w.value[15:0], RAW_LOW_WORD};
            MODE2:       r = w.value;
            TEMPERATURE: r = w.value;
        endcase
        return r;
    endfunction

    // Clock edges; port is synchronous to the reference clock
    assign selected  = !SERIAL_SELECT_LOW;
    assign sck_rise  = selected && SERIAL_CLOCK && !sck_q;
    assign sck_fall  = selected && !SERIAL_CLOCK && sck_q;
    assign byte_done = sck_fall && (bit_cnt_q == 3'h7);
    assign byte_in   = {shift_in_q[6:0], SERIAL_DATA_IN};
    assign op_addr   = opcode_q[2:0];
    assign is_id     = (opcode_q == OP_READ_ID);
    assign is_read   = (opcode_q[7:4] == OP_READ_HIGH) && !opcode_q[3] && !is_id;
    assign is_write  = (opcode_q[7:3] == OP_WRITE_HIGH) && (op_addr <= CFG_ADDR_LAST);
    assign data_index = byte_cnt_q - 4'h1;

    // Byte to send at the start of each data byte
    always_comb begin
        next_byte = 8'h00;
        if (is_id && data_index < ID_BYTES) begin
            next_byte = CONFIG_WORDS[data_index[2:0]][7:0];
        end else if (is_read) begin
            if (op_addr <= ADDR_RESULT_LAST && data_index < RESULT_BYTES) begin
                next_byte = results_q[op_addr[1:0]][8*(3-data_index[1:0]) +: 8];
            end else if (op_addr == ADDR_STATUS && data_index < STATUS_BYTES) begin
                next_byte = data_index[0] ? status_q[7:0] : status_q[15:8];
            end else if (op_addr == ADDR_TEST && data_index < TEST_BYTES) begin
                next_byte = CONFIG_WORDS[TEST_CFG_WORD][31:24];
            end
        end
    end

    // Receive side: sample on falling edge, select high resets
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sck_q      <= 1'b0;
            bit_cnt_q  <= '0;
            byte_cnt_q <= '0;
            shift_in_q <= '0;
            opcode_q   <= '0;
        end else begin
            sck_q <= SERIAL_CLOCK;
            if (!selected) begin
                bit_cnt_q  <= '0;
                byte_cnt_q <= '0;
                opcode_q   <= '0;
            end else if (sck_fall) begin
                bit_cnt_q  <= bit_cnt_q + 3'h1;
                shift_in_q <= byte_in;
                if (byte_done) begin
                    if (byte_cnt_q == 4'h0) begin
                        opcode_q <= byte_in;
                    end
                    if (byte_cnt_q != 4'hF) begin
                        byte_cnt_q <= byte_cnt_q + 4'h1;
                    end
                end
            end
        end
    end

    // Transmit side: next bit on rising edge, MSB first
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SERIAL_DATA_OUT    <= 1'b0;
            SERIAL_DATA_OUT_EN <= 1'b0;
            shift_out_q        <= '0;
        end else begin
            SERIAL_DATA_OUT_EN <= selected;
            if (!selected) begin
                SERIAL_DATA_OUT <= 1'b0;
                shift_out_q     <= '0;
            end else if (sck_rise) begin
                if (bit_cnt_q == 3'h0 && byte_cnt_q != 4'h0) begin
                    SERIAL_DATA_OUT <= next_byte[7];
                    shift_out_q     <= {next_byte[6:0], 1'b0};
                end else begin
                    SERIAL_DATA_OUT <= shift_out_q[7];
                    shift_out_q     <= {shift_out_q[6:0], 1'b0};
                end
            end
        end
    end

    // Configuration words: serial writes and recall
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            CONFIG_WORDS <= '0;
            write_acc_q  <= '0;
        end else if (recall_valid) begin
            CONFIG_WORDS <= recall_words;
        end else if (byte_done && is_write && byte_cnt_q != 4'h0) begin
            write_acc_q <= {write_acc_q[7:0], byte_in};
            if (byte_cnt_q == WRITE_UPPER) begin
                CONFIG_WORDS[op_addr][31:8] <= {write_acc_q, byte_in};
            end else if (byte_cnt_q == WRITE_LOWER) begin
                CONFIG_WORDS[op_addr][7:0] <= byte_in;
            end
        end
    end

    // Store actions launched at the end of the opcode byte
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            nvm_start_q <= 1'b0;
            nvm_op_q    <= NVM_STORE;
        end else begin
            nvm_start_q <= 1'b0;
            if (byte_done && byte_cnt_q == 4'h0 && !NVM_BUSY && !nvm_start_q) begin
                unique case (byte_in)
                    OP_NVM_STORE: begin
                        nvm_start_q <= 1'b1;
                        nvm_op_q    <= NVM_STORE;
                    end
                    OP_NVM_RECALL: begin
                        nvm_start_q <= 1'b1;
                        nvm_op_q    <= NVM_RECALL;
                    end
                    OP_NVM_COMPARE: begin
                        nvm_start_q <= 1'b1;
                        nvm_op_q    <= NVM_COMPARE;
                    end
                    default: nvm_start_q <= 1'b0;
                endcase
            end
        end
    end

    // Done pulse toward the host
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            NVM_DONE <= 1'b0;
        end else begin
            NVM_DONE <= nvm_done;
        end
    end

    // Result registers, changed only by the engine
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            for (int i = 0; i < 4; i++) begin
                results_q[i] <= RESULT_RESET;
            end
        end else if (RESULT_WRITE.valid) begin
            results_q[RESULT_WRITE.index] <= format_result(RESULT_WRITE);
        end
    end

    // Status word
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= {nvm_flags.single_fixed,
                         nvm_flags.nvm_uncorrectable_flag,
                         nvm_flags.nvm_matches_config,
                         ENGINE_STATUS.sensor_short,
                         ENGINE_STATUS.sensor_open,
                         ENGINE_STATUS.precount_timeout,
                         ENGINE_STATUS.tdc_timeout,
                         ENGINE_STATUS.hits_ch2,
                         ENGINE_STATUS.hits_ch1,
                         ENGINE_STATUS.next_pointer};
        end
    end

    // Protected configuration store
    nvm_config_store #(
        .ACTION_CYCLES (NVM_CYCLES)
    ) u_nvm (
        .clk          (REF_CLK),
        .rst          (RST),
        .start        (nvm_start_q),
        .op           (nvm_op_q),
        .cfg_words    (CONFIG_WORDS),
        .fault_mask   (NVM_FAULT_MASK),
        .busy         (NVM_BUSY),
        .done         (nvm_done),
        .recall_valid (recall_valid),
        .recall_words (recall_words),
        .flags        (nvm_flags)
    );

    // Helper: length of the current store action
    logic [31:0] busy_len_q;
    always_ff @(posedge REF_CLK) begin
        if (RST || !NVM_BUSY) begin
            busy_len_q <= '0;
        end else begin
            busy_len_q <= busy_len_q + 32'h0000_0001;
        end
    end

    // Checks
    chk_out_released: assert property (@(posedge REF_CLK) disable iff (RST)
        SERIAL_SELECT_LOW |=> !SERIAL_DATA_OUT_EN)
        else $error("data out driven while deselected");

    chk_out_on_rise: assert property (@(posedge REF_CLK) disable iff (RST)
        selected && $past(selected) && $changed(SERIAL_DATA_OUT) |-> $past(sck_rise))
        else $error("data out changed away from a rising clock");

    chk_overflow_ones: assert property (@(posedge REF_CLK) disable iff (RST)
        RESULT_WRITE.valid && RESULT_WRITE.kind == MODE1_CAL && RESULT_WRITE.alu_overflow
        |=> results_q[$past(RESULT_WRITE.index)] == RESULT_OVERFLOW)
        else $error("overflow did not write all ones");

    chk_raw_format: assert property (@(posedge REF_CLK) disable iff (RST)
        RESULT_WRITE.valid && RESULT_WRITE.kind == MODE1_RAW
        |=> results_q[$past(RESULT_WRITE.index)] == {$past(RESULT_WRITE.value[15:0]), 16'h0000})
        else $error("raw result format wrong");

    chk_mode2_plain: assert property (@(posedge REF_CLK) disable iff (RST)
        RESULT_WRITE.valid && RESULT_WRITE.kind != MODE1_RAW && !RESULT_WRITE.alu_overflow
        |=> results_q[$past(RESULT_WRITE.index)] == $past(RESULT_WRITE.value))
        else $error("calibrated result altered");

    chk_results_held: assert property (@(posedge REF_CLK) disable iff (RST)
        !RESULT_WRITE.valid |=> results_q[0] == $past(results_q[0])
                                && results_q[3] == $past(results_q[3]))
        else $error("result changed without a write");

    chk_status_fields: assert property (@(posedge REF_CLK) disable iff (RST)
        1'b1 |=> status_q[12:0] == $past({ENGINE_STATUS.sensor_short, ENGINE_STATUS.sensor_open,
                 ENGINE_STATUS.precount_timeout, ENGINE_STATUS.tdc_timeout,
                 ENGINE_STATUS.hits_ch2, ENGINE_STATUS.hits_ch1, ENGINE_STATUS.next_pointer}))
        else $error("status fields out of place");

    chk_compare_flag: assert property (@(posedge REF_CLK) disable iff (RST)
        nvm_done && nvm_op_q == NVM_COMPARE |=> status_q[13] == $past(nvm_flags.nvm_matches_config))
        else $error("compare result not in status bit 13");

    chk_action_bound: assert property (@(posedge REF_CLK) disable iff (RST)
        busy_len_q <= 32'(NVM_CYCLES))
        else $error("store action ran too long");

    chk_action_starts: assert property (@(posedge REF_CLK) disable iff (RST)
        nvm_start_q && !NVM_BUSY |=> NVM_BUSY ##0 !NVM_DONE)
        else $error("store action did not start");

endmodule // tdc_result_status_readout

// File: tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    input  wire logic so,
    input  wire logic so_en,
    output logic      ssn_low,
    output logic      sck,
    output logic      si
);
    // Deselected, clock idles low
    initial begin
        ssn_low = 1'b1;
        sck     = 1'b0;
        si      = 1'b0;
    end
    // Opcode then n bytes, each bit half period four cycles
    task automatic frame(input logic [7:0] op, input int n, input logic [31:0] wd,
                         output logic [55:0] rd);
        logic [39:0] sh;
        sh = {op, wd};
        rd = '0;
        #1 ssn_low = 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8 * (n + 1); i++) begin
            #1 sck = 1'b1;
            si = sh[39];
            sh = sh << 1;
            repeat (4) @(posedge clk);
            #1 sck = 1'b0;
            rd = {rd[54:0], so_en ? so : 1'b1};
            repeat (4) @(posedge clk);
        end
        #1 ssn_low = 1'b1;
        si = ~si;
        repeat (2) @(posedge clk);
    endtask
endmodule // spi_host_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tdc_readout_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst = 1'b1;
    logic              ssn_low, sck, si, so, oe, busy, done;
    result_write_type  rw = '0;
    engine_status_type es = 13'h1A5B;
    logic [38:0]       fault = '0;
    logic [6:0][31:0]  cfg;
    logic [55:0]       rd;
    int                error_cnt = 0;
    int                cmp_count = 0;
    // Clock
    always #50 ref_clk = ~ref_clk;
    spi_host_model i_host (.clk(ref_clk), .so(so), .so_en(oe), .ssn_low(ssn_low), .sck(sck),
        .si(si));
    tdc_result_status_readout #(.NVM_CYCLES(20)) i_dut (.REF_CLK(ref_clk), .RST(rst),
        .SERIAL_SELECT_LOW(ssn_low), .SERIAL_CLOCK(sck), .SERIAL_DATA_IN(si),
        .SERIAL_DATA_OUT(so), .SERIAL_DATA_OUT_EN(oe), .RESULT_WRITE(rw), .ENGINE_STATUS(es),
        .NVM_FAULT_MASK(fault), .CONFIG_WORDS(cfg), .NVM_BUSY(busy), .NVM_DONE(done));
    // Verdict and end of run
    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [55:0] got, input logic [55:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] op, input int n, input logic [55:0] exp);
        i_host.frame(op, n, 32'h0000_0000, rd);
        chk(rd, exp);
        chk(oe, 1'b0);
    endtask
    // Store action with bounded wait for its end pulse
    task automatic nvm(input logic [7:0] op, input logic [38:0] fm);
        int k;
        i_host.frame(op, 0, 32'h0000_0000, rd);
        chk(busy, 1'b1);
        #1 fault = fm;
        for (k = 0; k < 200; k++) begin
            @(posedge ref_clk);
            #2;
            if (done === 1'b1) break;
        end
        if (k == 200) begin
            error_cnt++;
            finish_test();
        end
        chk(busy, 1'b0);
        repeat (3) @(posedge ref_clk);
    endtask
    // One result write pulse
    task automatic put(input logic [1:0] ix, input result_kind_type kd, input logic ov,
                       input logic [31:0] v);
        #1 rw = '{1'b1, ix, kd, ov, v};
        @(posedge ref_clk);
        #1 rw.valid = 1'b0;
        @(posedge ref_clk);
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
        @(posedge ref_clk);
        for (int k = 0; k < 7; k++) begin
            i_host.frame(8'h80 + k[7:0], 4, {8'hA0 + k[7:0], 16'h1234, 8'h20 + k[7:0]}, rd);
        end
        rd_chk(8'hB7, 7, 56'h20_2122_2324_2526);
        rd_chk(8'hB5, 1, 56'h00A1);
        rd_chk(8'hB4, 2, {3'b000, es});
        put(2'h0, MODE1_CAL, 1'b1, 32'h0001_8000);
        put(2'h1, MODE1_RAW, 1'b0, 32'h8001_8001);
        put(2'h2, MODE2, 1'b0, 32'hF012_3456);
        put(2'h3, TEMPERATURE, 1'b0, 32'h0000_ABCD);
        rd_chk(8'hB0, 4, 56'hFFFF_FFFF);
        rd_chk(8'hB1, 4, 56'h8001_0000);
        rd_chk(8'hB2, 4, 56'hF012_3456);
        rd_chk(8'hB3, 4, 56'hABCD);
        rd_chk(8'hB3, 4, 56'hABCD);
        nvm(OP_NVM_STORE, '0);
        nvm(OP_NVM_COMPARE, '0);
        rd_chk(8'hB4, 2, {3'b001, es});
        i_host.frame(8'h82, 4, 32'hFFFF_FFFF, rd);
        nvm(OP_NVM_COMPARE, '0);
        rd_chk(8'hB4, 2, {3'b000, es});
        nvm(OP_NVM_RECALL, '0);
        chk(cfg[2], 32'hA212_3422);
        nvm(OP_NVM_STORE, 39'h8);
        nvm(OP_NVM_RECALL, '0);
        chk(cfg[0], 32'hA012_3420);
        rd_chk(8'hB4, 2, {3'b100, es});
        nvm(OP_NVM_STORE, 39'h3);
        nvm(OP_NVM_RECALL, '0);
        rd_chk(8'hB4, 2, {3'b010, es});
        finish_test();
    end
endmodule // tb_top
